// >>> bench/isa_master.sv
`timescale 1ns/100ps
`default_nettype none
// Bridge side of the ISA bus; strobes held long enough for the synchronisers
module isa_master (
	input  wire logic       clk_sys,
	output logic      [2:0] sa,
	output logic      [2:0] ecas_addr,
	output logic            ior_n,
	output logic            iow_n,
	output logic      [7:0] sd_in,
	input  wire logic [7:0] sd_out,
	input  wire logic       sd_oe
);
	initial begin
		sa = 3'h0;
		ecas_addr = 3'h0;
		ior_n = 1'b1;
		iow_n = 1'b1;
		sd_in = 8'h00;
	end
	task automatic io_write(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sa = a;
		sd_in = d;
		iow_n = 1'b0;
		repeat (5) @(negedge clk_sys);
		iow_n = 1'b1;
		@(negedge clk_sys);
		// Released lines flip so a stale value cannot pass
		sa = ~a;
		sd_in = ~d;
		repeat (6) @(negedge clk_sys);
	endtask
	task automatic io_read(input logic [2:0] a, output logic [7:0] d, output logic ok);
		d = 8'hXX;
		ok = 1'b0;
		@(negedge clk_sys);
		sa = a;
		ior_n = 1'b0;
		for (int i = 0; i < 10 && !ok; i++) begin
			@(negedge clk_sys);
			if (sd_oe === 1'b1) begin
				d = sd_out;
				ok = 1'b1;
			end
		end
		ior_n = 1'b1;
		sa = ~a;
		repeat (6) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> bench/pci_irq_mask_combiner_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pci_irq_mask_combiner_checker (
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic       rtc_irq_n,
	input wire logic       bridge_nmi,
	input wire logic       host_bridge_hw_request,
	input wire logic [2:0] clk_mult_jumper,
	input wire logic       ior_n,
	input wire logic [7:0] sd_out,
	input wire logic       sd_oe,
	input wire logic       cpu_int_line_0,
	input wire logic       cpu_int_line_1,
	input wire logic       cpu_int_line_2,
	input wire logic       cpu_int_line_3,
	input wire logic       cpu_int_line_4,
	input wire logic       cpu_int_line_5
);
	// Cycles since reset release and since reset entry, saturating
	logic [2:0] run_q = 3'h0;
	logic [2:0] rst_q = 3'h0;
	// Outputs are unknown before the first edge
	logic       live_q = 1'b0;
	always_ff @(posedge clk_sys) begin
		live_q <= 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (srst)
			run_q <= 3'h0;
		else if (run_q != 3'h7)
			run_q <= run_q + 3'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (!srst)
			rst_q <= 3'h0;
		else if (rst_q != 3'h7)
			rst_q <= rst_q + 3'h1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	property p_gnd;
		live_q |-> !cpu_int_line_3 && !cpu_int_line_4;
	endproperty
	a_gnd: assert property (p_gnd) else $error("line 3 or 4 high");
	property p_rtc;
		disable iff (srst) run_q >= 3'h3 |-> cpu_int_line_1 == !$past(rtc_irq_n, 3);
	endproperty
	a_rtc: assert property (p_rtc) else $error("line 1 wrong");
	property p_pass;
		disable iff (srst) run_q >= 3'h3 |-> cpu_int_line_2 == $past(bridge_nmi, 3)
			&& cpu_int_line_5 == $past(host_bridge_hw_request, 3);
	endproperty
	a_pass: assert property (p_pass) else $error("line 2 or 5 wrong");
	property p_jump;
		srst && rst_q >= 3'h4 && $past(clk_mult_jumper, 4) == clk_mult_jumper
			|-> {cpu_int_line_2, cpu_int_line_1, cpu_int_line_0} == clk_mult_jumper;
	endproperty
	a_jump: assert property (p_jump) else $error("jumpers not shown");
	property p_rquiet;
		srst && rst_q >= 3'h2 |-> !sd_oe && !cpu_int_line_5 && sd_out == 8'h00;
	endproperty
	a_rquiet: assert property (p_rquiet) else $error("busy in reset");
	property p_quiet;
		disable iff (srst) !sd_oe |-> sd_out == 8'h00;
	endproperty
	a_quiet: assert property (p_quiet) else $error("data while idle");
	property p_oe;
		disable iff (srst) $rose(sd_oe) |-> !$past(ior_n, 3) && !$past(ior_n, 4);
	endproperty
	a_oe: assert property (p_oe) else $error("drive without read");
	property p_hold;
		disable iff (srst) sd_oe && !ior_n && !$past(ior_n, 2) |=> sd_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("drive dropped");
	c_read: cover property ($rose(sd_oe));
	c_comb: cover property (!srst && cpu_int_line_0);
	c_rst: cover property ($fell(srst));
endmodule
bind pci_irq_mask_combiner pci_irq_mask_combiner_checker pci_irq_mask_combiner_checker_inst (
	.clk_sys(clk_sys), .srst(srst), .rtc_irq_n(rtc_irq_n), .bridge_nmi(bridge_nmi),
	.host_bridge_hw_request(host_bridge_hw_request), .clk_mult_jumper(clk_mult_jumper),
	.ior_n(ior_n), .sd_out(sd_out), .sd_oe(sd_oe), .cpu_int_line_0(cpu_int_line_0),
	.cpu_int_line_1(cpu_int_line_1), .cpu_int_line_2(cpu_int_line_2),
	.cpu_int_line_3(cpu_int_line_3), .cpu_int_line_4(cpu_int_line_4),
	.cpu_int_line_5(cpu_int_line_5));
`default_nettype wire

// >>> bench/pci_irq_mask_combiner_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pci_irq_mask_combiner_tb;
	typedef struct packed {logic [16:0] src; logic [23:0] mask; logic exp;} row_t;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [16:0] src = 17'h0;
	logic        rtc_irq_n = 1'b1;
	logic        bridge_nmi = 1'b0;
	logic        host_req = 1'b0;
	logic [2:0]  jmp = 3'h5;
	logic [2:0]  sa;
	logic [2:0]  ecas_addr;
	logic        ior_n;
	logic        iow_n;
	logic [7:0]  sd_in;
	logic [7:0]  sd_out;
	logic [7:0]  rd;
	logic        sd_oe;
	logic        ok;
	logic [5:0]  line;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles = 0;
	// Mask bytes ordered high, mid, low
	row_t rows [5] = '{'{17'h00001, 24'h01FFFE, 1'b1}, '{17'h10000, 24'h00FFFF, 1'b1},
		'{17'h1FFFF, 24'hFFFFFF, 1'b0}, '{17'h00100, 24'h01FEFF, 1'b1},
		'{17'h0AA55, 24'hFEAA55, 1'b0}};
	pci_irq_mask_combiner pci_irq_mask_combiner_inst (.clk_sys(clk_sys), .srst(srst),
		.slot0_pin_a(src[0]), .slot1_pin_a(src[1]), .slot2_pin_a(src[2]),
		.slot3_pin_a(src[3]), .bridge_irq(src[4]), .slot0_pin_b(src[5]),
		.slot1_pin_b(src[6]), .slot2_pin_b(src[7]), .slot3_pin_b(src[8]),
		.slot0_pin_c(src[9]), .slot1_pin_c(src[10]), .slot2_pin_c(src[11]),
		.slot3_pin_c(src[12]), .slot0_pin_d(src[13]), .slot1_pin_d(src[14]),
		.slot2_pin_d(src[15]), .slot3_pin_d(src[16]), .rtc_irq_n(rtc_irq_n),
		.bridge_nmi(bridge_nmi), .host_bridge_hw_request(host_req), .clk_mult_jumper(jmp),
		.sa(sa), .ecas_addr(ecas_addr), .ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in),
		.sd_out(sd_out), .sd_oe(sd_oe), .cpu_int_line_0(line[0]), .cpu_int_line_1(line[1]),
		.cpu_int_line_2(line[2]), .cpu_int_line_3(line[3]), .cpu_int_line_4(line[4]),
		.cpu_int_line_5(line[5]));
	isa_master isa_master_inst (.clk_sys(clk_sys), .sa(sa), .ecas_addr(ecas_addr),
		.ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe));
	always #5 clk_sys = ~clk_sys;
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rd_all(input logic [16:0] s);
		isa_master_inst.io_read(3'h4, rd, ok);
		chk(rd, s[7:0]);
		isa_master_inst.io_read(3'h5, rd, ok);
		chk(rd, s[15:8]);
		isa_master_inst.io_read(3'h6, rd, ok);
		chk(rd, {7'h00, s[16]});
	endtask
	task automatic wr_all(input logic [23:0] m);
		isa_master_inst.io_write(3'h4, m[7:0]);
		isa_master_inst.io_write(3'h5, m[15:8]);
		isa_master_inst.io_write(3'h6, m[23:16]);
	endtask
	initial begin
		repeat (9) @(negedge clk_sys);
		chk({5'h0, line[2:0]}, {5'h0, jmp});
		chk({5'h0, line[5:3]}, 8'h00);
		@(negedge clk_sys);
		srst = 1'b0;
		src = 17'h1FFFF;
		repeat (4) @(negedge clk_sys);
		chk(line[0], 1'b0);
		rd_all(17'h1FFFF);
		foreach (rows[i]) begin
			wr_all(rows[i].mask);
			src = rows[i].src;
			repeat (4) @(negedge clk_sys);
			chk(line[0], rows[i].exp);
			rd_all(rows[i].src);
		end
		// A stray decode of the low location would unmask the pending sources
		isa_master_inst.io_write(3'h7, 8'h00);
		isa_master_inst.io_read(3'h3, rd, ok);
		chk({7'h00, ok}, 8'h00);
		chk(line[0], 1'b0);
		// Right low address under a foreign extended decode must stay silent
		isa_master_inst.ecas_addr = 3'h1;
		isa_master_inst.io_write(3'h4, 8'h00);
		isa_master_inst.io_read(3'h4, rd, ok);
		isa_master_inst.ecas_addr = 3'h0;
		chk({7'h00, ok}, 8'h00);
		chk(line[0], 1'b0);
		for (int k = 0; k < 8; k++) begin
			{rtc_irq_n, bridge_nmi, host_req} = k[2:0];
			repeat (4) @(negedge clk_sys);
			chk(line[5:1], {host_req, 2'b00, bridge_nmi, ~rtc_irq_n});
		end
		wr_all(24'h000000);
		src = 17'h00010;
		repeat (4) @(negedge clk_sys);
		chk(line[0], 1'b1);
		srst = 1'b1;
		jmp = 3'h2;
		repeat (10) @(negedge clk_sys);
		chk({5'h0, line[2:0]}, {5'h0, jmp});
		chk({5'h0, line[5:3]}, 8'h00);
		srst = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(line[0], 1'b0);
		rd_all(17'h00010);
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> common/irq_combiner_pkg.sv
package irq_combiner_pkg;

	localparam int NUM_SOURCES = 17;
	localparam int BYTE_W      = 8;

	// Byte locations of the three state/mask registers
	localparam logic [11:0] PCI_IRQ_STATE_MASK_LOW_OFS  = 12'h804;
	localparam logic [11:0] PCI_IRQ_STATE_MASK_MID_OFS  = 12'h805;
	localparam logic [11:0] PCI_IRQ_STATE_MASK_HIGH_OFS = 12'h806;

	// Bit positions of each source in the 17-bit source vector.
	// Bits 7:0 are the low location, 15:8 the mid, 16 the high bit 0.
	localparam int IDX_SLOT0_A = 0;
	localparam int IDX_SLOT1_A = 1;
	localparam int IDX_SLOT2_A = 2;
	localparam int IDX_SLOT3_A = 3;
	localparam int IDX_BRIDGE  = 4;
	localparam int IDX_SLOT0_B = 5;
	localparam int IDX_SLOT1_B = 6;
	localparam int IDX_SLOT2_B = 7;
	localparam int IDX_SLOT3_B = 8;
	localparam int IDX_SLOT0_C = 9;
	localparam int IDX_SLOT1_C = 10;
	localparam int IDX_SLOT2_C = 11;
	localparam int IDX_SLOT3_C = 12;
	localparam int IDX_SLOT0_D = 13;
	localparam int IDX_SLOT1_D = 14;
	localparam int IDX_SLOT2_D = 15;
	localparam int IDX_SLOT3_D = 16;

	localparam int LOW_BASE  = 0;
	localparam int MID_BASE  = 8;
	localparam int HIGH_BASE = 16;
	localparam int HIGH_BITS = 1;

	localparam logic [NUM_SOURCES-1:0] MASK_RESET = 17'h1FFFF;
	localparam logic [BYTE_W-1:0]      BYTE_ZERO  = 8'h00;

	typedef enum logic [1:0] {
		LOC_LOW,
		LOC_MID,
		LOC_HIGH,
		LOC_NONE
	} reg_loc_t;

endpackage

// >>> src/pci_irq_mask_combiner.sv
`timescale 1ns/100ps
`default_nettype none

module pci_irq_mask_combiner
	import irq_combiner_pkg::*;
#(
	// Extended decode pattern that qualifies the 80xh window
	parameter logic [2:0] ECAS_IRQ_WINDOW = 3'h0
) (
	input  wire logic                             clk_sys,
	input  wire logic                             srst,
	// PCI interrupt sources, active high at this block
	input  wire logic                             slot0_pin_a,
	input  wire logic                             slot1_pin_a,
	input  wire logic                             slot2_pin_a,
	input  wire logic                             slot3_pin_a,
	input  wire logic                             slot0_pin_b,
	input  wire logic                             slot1_pin_b,
	input  wire logic                             slot2_pin_b,
	input  wire logic                             slot3_pin_b,
	input  wire logic                             slot0_pin_c,
	input  wire logic                             slot1_pin_c,
	input  wire logic                             slot2_pin_c,
	input  wire logic                             slot3_pin_c,
	input  wire logic                             slot0_pin_d,
	input  wire logic                             slot1_pin_d,
	input  wire logic                             slot2_pin_d,
	input  wire logic                             slot3_pin_d,
	input  wire logic                             bridge_irq,
	// Other CPU interrupt sources
	input  wire logic                             rtc_irq_n,
	input  wire logic                             bridge_nmi,
	input  wire logic                             host_bridge_hw_request,
	// Clock multiplier jumpers
	input  wire logic [2:0]                       clk_mult_jumper,
	// ISA I/O slave
	input  wire logic [2:0]                       sa,
	input  wire logic [2:0]                       ecas_addr,
	input  wire logic                             ior_n,
	input  wire logic                             iow_n,
	input  wire logic [irq_combiner_pkg::BYTE_W-1:0] sd_in,
	output logic      [irq_combiner_pkg::BYTE_W-1:0] sd_out,
	output logic                                  sd_oe,
	// CPU interrupt inputs
	output logic                                  cpu_int_line_0,
	output logic                                  cpu_int_line_1,
	output logic                                  cpu_int_line_2,
	output logic                                  cpu_int_line_3,
	output logic                                  cpu_int_line_4,
	output logic                                  cpu_int_line_5
);

	import irq_combiner_pkg::*;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ,
		BUS_WRITE
	} bus_state_t;

	localparam int NUM_MISC = 3;
	localparam int NUM_BUS  = 3 + 3 + 2 + BYTE_W;

	// Map a decoded location plus byte to the 17-bit mask update
	function automatic logic [NUM_SOURCES-1:0] apply_byte(
		input logic [NUM_SOURCES-1:0] cur,
		input reg_loc_t               loc,
		input logic [BYTE_W-1:0]      data
	);
		logic [NUM_SOURCES-1:0] res;
		res = cur;
		unique case (loc)
			LOC_LOW:  res[LOW_BASE +: BYTE_W] = data;
			LOC_MID:  res[MID_BASE +: BYTE_W] = data;
			// Upper bits of the high byte have nowhere to land
			LOC_HIGH: res[HIGH_BASE +: HIGH_BITS] = data[HIGH_BITS-1:0];
			LOC_NONE: res = cur;
		endcase
		return res;
	endfunction

	// Select the byte of the source vector that a location reports
	function automatic logic [BYTE_W-1:0] read_byte(
		input logic [NUM_SOURCES-1:0] vec,
		input reg_loc_t               loc
	);
		logic [BYTE_W-1:0] res;
		res = BYTE_ZERO;
		unique case (loc)
			LOC_LOW:  res = vec[LOW_BASE +: BYTE_W];
			LOC_MID:  res = vec[MID_BASE +: BYTE_W];
			LOC_HIGH: res[HIGH_BITS-1:0] = vec[HIGH_BASE +: HIGH_BITS];
			LOC_NONE: res = BYTE_ZERO;
		endcase
		return res;
	endfunction

	// Decode the six address lines into one of the three locations, or LOC_NONE when none matches
	function automatic reg_loc_t decode_loc(
		input logic [2:0] low_addr,
		input logic [2:0] ext_addr
	);
		reg_loc_t res;
		res = LOC_NONE;
		if (ext_addr == ECAS_IRQ_WINDOW) begin
			if (low_addr == PCI_IRQ_STATE_MASK_LOW_OFS[2:0]) begin
				res = LOC_LOW;
			end else if (low_addr == PCI_IRQ_STATE_MASK_MID_OFS[2:0]) begin
				res = LOC_MID;
			end else if (low_addr == PCI_IRQ_STATE_MASK_HIGH_OFS[2:0]) begin
				res = LOC_HIGH;
			end
		end
		return res;
	endfunction

	logic [NUM_SOURCES-1:0] src_raw;
	logic [NUM_SOURCES-1:0] src_sync;
	logic [NUM_MISC-1:0]    misc_raw;
	logic [NUM_MISC-1:0]    misc_sync;
	logic [2:0]             jumper_sync;
	logic [NUM_BUS-1:0]     bus_raw;
	logic [NUM_BUS-1:0]     bus_sync;
	logic [2:0]             sa_s;
	logic [2:0]             ecas_s;
	logic                   ior_n_s;
	logic                   iow_n_s;
	logic [BYTE_W-1:0]      sd_in_s;
	reg_loc_t               bus_loc;

	bus_state_t             bus_state_q;
	reg_loc_t               loc_q;
	logic [BYTE_W-1:0]      wr_data_q;
	logic [NUM_SOURCES-1:0] mask_q;
	logic                   combined_req;

	// Gather the sources in register bit order
	always_comb begin
		src_raw              = '0;
		src_raw[IDX_SLOT0_A] = slot0_pin_a;
		src_raw[IDX_SLOT1_A] = slot1_pin_a;
		src_raw[IDX_SLOT2_A] = slot2_pin_a;
		src_raw[IDX_SLOT3_A] = slot3_pin_a;
		src_raw[IDX_BRIDGE]  = bridge_irq;
		src_raw[IDX_SLOT0_B] = slot0_pin_b;
		src_raw[IDX_SLOT1_B] = slot1_pin_b;
		src_raw[IDX_SLOT2_B] = slot2_pin_b;
		src_raw[IDX_SLOT3_B] = slot3_pin_b;
		src_raw[IDX_SLOT0_C] = slot0_pin_c;
		src_raw[IDX_SLOT1_C] = slot1_pin_c;
		src_raw[IDX_SLOT2_C] = slot2_pin_c;
		src_raw[IDX_SLOT3_C] = slot3_pin_c;
		src_raw[IDX_SLOT0_D] = slot0_pin_d;
		src_raw[IDX_SLOT1_D] = slot1_pin_d;
		src_raw[IDX_SLOT2_D] = slot2_pin_d;
		src_raw[IDX_SLOT3_D] = slot3_pin_d;
	end

	// RTC line is active low at the pin; CPU lines are active high
	assign misc_raw = {host_bridge_hw_request, bridge_nmi, ~rtc_irq_n};
	assign bus_raw  = {sa, ecas_addr, ior_n, iow_n, sd_in};

	sync_bank #(
		.WIDTH     (NUM_SOURCES),
		.RESET_VAL (1'h0)
	) u_src_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in (src_raw),
		.sync_out (src_sync)
	);

	sync_bank #(
		.WIDTH     (NUM_MISC),
		.RESET_VAL (1'h0)
	) u_misc_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in (misc_raw),
		.sync_out (misc_sync)
	);

	// Jumpers must keep flowing while reset is held, so no reset here
	sync_bank #(
		.WIDTH     (3),
		.RESET_VAL (1'h0)
	) u_jumper_sync (
		.clk_sys  (clk_sys),
		.srst     (1'b0),
		.async_in (clk_mult_jumper),
		.sync_out (jumper_sync)
	);

	// Strobes idle high, so they reset to the inactive level
	sync_bank #(
		.WIDTH     (NUM_BUS),
		.RESET_VAL (1'h1)
	) u_bus_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in (bus_raw),
		.sync_out (bus_sync)
	);

	assign {sa_s, ecas_s, ior_n_s, iow_n_s, sd_in_s} = bus_sync;
	assign bus_loc = decode_loc(sa_s, ecas_s);

	// Bus cycle tracking; the location is frozen at strobe start so a
	// wandering address cannot retarget a cycle already under way
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bus_state_q <= BUS_IDLE;
			loc_q       <= LOC_NONE;
		end else begin
			unique case (bus_state_q)
				BUS_IDLE: begin
					if (!ior_n_s && bus_loc != LOC_NONE) begin
						bus_state_q <= BUS_READ;
						loc_q       <= bus_loc;
					end else if (!iow_n_s && bus_loc != LOC_NONE) begin
						bus_state_q <= BUS_WRITE;
						loc_q       <= bus_loc;
					end
				end
				BUS_READ: begin
					if (ior_n_s) begin
						bus_state_q <= BUS_IDLE;
						loc_q       <= LOC_NONE;
					end
				end
				BUS_WRITE: begin
					if (iow_n_s) begin
						bus_state_q <= BUS_IDLE;
						loc_q       <= LOC_NONE;
					end
				end
				default: begin
					bus_state_q <= BUS_IDLE;
					loc_q       <= LOC_NONE;
				end
			endcase
		end
	end

	// Keep sampling write data while the strobe is low; the last sample
	// before the rising edge is the one committed
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_data_q <= BYTE_ZERO;
		end else if (bus_state_q == BUS_WRITE && !iow_n_s) begin
			wr_data_q <= sd_in_s;
		end
	end

	// Mask store: written only, never read back
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mask_q <= MASK_RESET;
		end else if (bus_state_q == BUS_WRITE && iow_n_s) begin
			mask_q <= apply_byte(mask_q, loc_q, wr_data_q);
		end
	end

	// Read data follows the live sources every cycle of the read
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sd_out <= BYTE_ZERO;
			sd_oe  <= 1'b0;
		end else if (bus_state_q == BUS_READ && !ior_n_s) begin
			sd_out <= read_byte(src_sync, loc_q);
			sd_oe  <= 1'b1;
		end else begin
			sd_out <= BYTE_ZERO;
			sd_oe  <= 1'b0;
		end
	end

	assign combined_req = |(src_sync & ~mask_q);

	// CPU line mux: jumpers during reset, interrupt sources afterwards
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cpu_int_line_0 <= jumper_sync[0];
			cpu_int_line_1 <= jumper_sync[1];
			cpu_int_line_2 <= jumper_sync[2];
			cpu_int_line_3 <= 1'b0;
			cpu_int_line_4 <= 1'b0;
			cpu_int_line_5 <= 1'b0;
		end else begin
			cpu_int_line_0 <= combined_req;
			cpu_int_line_1 <= misc_sync[0];
			cpu_int_line_2 <= misc_sync[1];
			cpu_int_line_3 <= 1'b0;
			cpu_int_line_4 <= 1'b0;
			cpu_int_line_5 <= misc_sync[2];
		end
	end

endmodule

`default_nettype wire

// >>> src/sync_bank.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a bank of independent levels
module sync_bank #(
	parameter int         WIDTH     = 1,
	parameter logic [0:0] RESET_VAL = 1'h0
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q   <= {WIDTH{RESET_VAL}};
			sync_out <= {WIDTH{RESET_VAL}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire
